//--- src/iorpc_pkg.sv
package iorpc_pkg;

  localparam int          NLINE      = 4;
  localparam int          AW         = 8;
  localparam int          DW         = 32;
  localparam logic [AW-1:0] A_IO_CTRL  = 8'h00;
  localparam logic [AW-1:0] A_IO_STAT  = 8'h04;
  localparam logic [AW-1:0] A_PWR_CTRL = 8'h08;
  localparam logic [AW-1:0] A_PWR_STAT = 8'h0C;
  localparam logic [AW-1:0] A_LED0     = 8'h10;
  localparam logic [AW-1:0] A_LED1     = 8'h14;

  localparam int LINE_EE_A = 0;
  localparam int LINE_EE_B = 1;
  localparam int LINE_MIC  = 2;
  localparam int LINE_GEN  = 3;
  localparam logic [NLINE-1:0] PULL_RST = 4'h7;

  localparam int CLK_NS      = 8;
  localparam int CLK_KHZ     = 125000;
  localparam int RST_MIN_MS  = 1300;
  localparam int RST_MAX_MS  = 1500;
  localparam int RST_CYC     = RST_MIN_MS * CLK_KHZ;
  localparam int I2C_QTR_NS  = 2500;
  localparam int I2C_QTR_CYC = (I2C_QTR_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] EE_RD_CMD  = 8'hA1;
  localparam logic [4:0] ACK_BIT    = 5'h08;
  localparam logic [4:0] RD_LAST    = 5'h10;
  localparam logic [4:0] NACK_BIT   = 5'h11;
  localparam logic [7:0] CHG_MIN_MA = 8'h14;
  localparam logic [7:0] CHG_MAX_MA = 8'h78;
  localparam logic [7:0] LED_FULL   = 8'hFF;

  typedef enum logic [2:0] {BT_IDLE, BT_START, BT_BIT, BT_STOP, BT_DONE} iorpc_boot_e;

  typedef struct packed {
    logic             mic_bias_on;
    logic             mic_bias_mode;
    logic [NLINE-1:0] pull_up;
    logic [NLINE-1:0] out;
    logic [NLINE-1:0] oe;
  } iorpc_io_ctrl_s;

  typedef struct packed {
    logic led_ovr;
    logic chg_off;
    logic sniff;
    logic smps_fw;
  } iorpc_pwr_ctrl_s;

  typedef struct packed {
    logic       en;
    logic [7:0] level;
  } iorpc_led_s;

  typedef struct packed {
    logic             chg_full;
    logic             chg_active;
    logic             supply;
    logic             key_b;
    logic             key_a;
    logic             ext_rst_n;
    logic [NLINE-1:0] gpio;
  } iorpc_pins_s;

  typedef struct packed {
    logic [6:0] chg_ma;
    logic       ee_nack;
    logic       boot_done;
    logic       supply;
    logic       chg_full;
    logic       chg_active;
    logic       pulse_skip;
    logic       smps_en;
  } iorpc_pwr_stat_s;

  localparam iorpc_io_ctrl_s IO_CTRL_RST = '{mic_bias_on: 1'b0, mic_bias_mode: 1'b0,
                                             pull_up: PULL_RST, out: 4'h0, oe: 4'h0};
  localparam iorpc_pins_s    PINS_RST    = '{ext_rst_n: 1'b1, default: '0};

endpackage

//--- src/iorpc_pwm.sv
`timescale 1ns/1ns
`default_nettype none
module iorpc_pwm
  import iorpc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_clk,   // System clock
  input  wire logic         i_rst_n, // Async reset, active low
  input  wire logic         i_en,    // Output switched on
  input  wire logic [W-1:0] i_level, // Intensity, all ones is full
  output logic              o_on     // Pad pulled low when high
);

  logic [W-1:0] cnt;
  wire          full   = &i_level;
  wire          next_on = i_en && (full || (cnt < i_level));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt  <= '0;
      o_on <= 1'b0;
    end else begin
      cnt  <= cnt + 1'b1;
      o_on <= next_on;
    end
  end

endmodule
`default_nettype wire

//--- src/iorpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module iorpc_top
  import iorpc_pkg::*;
#(
  parameter int RST_FILT_CYC = RST_CYC,
  parameter int QTR_CYC      = I2C_QTR_CYC
) (
  input  wire logic             i_clk,               // System clock
  input  wire logic             i_rst_n,             // Power-on reset, active low
  input  wire logic [AW-1:0]    i_addr,              // Register address
  input  wire logic [DW-1:0]    i_wdata,             // Write data
  input  wire logic             i_wr,                // Write strobe
  input  wire logic             i_rd,                // Read strobe
  output logic      [DW-1:0]    o_rdata,             // Read data, cycle after read
  input  wire logic [NLINE-1:0] i_gpio,              // Line levels
  output logic      [NLINE-1:0] o_gpio_out,          // Line drive values
  output logic      [NLINE-1:0] o_gpio_oe,           // Line drive enables
  output logic      [NLINE-1:0] o_pull_up,           // Pull-up enables
  output logic      [NLINE-1:0] o_pull_dn,           // Pull-down enables
  input  wire logic             i_ext_reset_n,       // External reset pin
  input  wire logic             i_power_key_a,       // Power key A
  input  wire logic             i_power_key_b,       // Power key B
  input  wire logic             i_charger_supply_in, // Charger supply present
  input  wire logic             i_chg_active,        // Charger is charging
  input  wire logic             i_chg_full,          // Charger reports full
  output logic                  o_sys_rst_n,         // Filtered reset, active low
  output logic                  o_smps_en,           // Regulator enable
  output logic                  o_smps_pulse_skip,   // Regulator low-power mode
  output logic                  o_chg_disable,       // Charger off
  output logic      [6:0]       o_chg_current,       // Charge current in mA
  output logic      [1:0]       o_led_out,           // LED pad values
  output logic      [1:0]       o_led_oe             // LED pad enables
);

  localparam int CW = $clog2(RST_FILT_CYC + 1);
  localparam int QW = $clog2(QTR_CYC + 1);

  function automatic logic [6:0] clamp_ma(input logic [7:0] v);
    logic [7:0] c;
    c = v;
    if (v < CHG_MIN_MA) begin
      c = CHG_MIN_MA;
    end else if (v > CHG_MAX_MA) begin
      c = CHG_MAX_MA;
    end
    return c[6:0];
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  iorpc_pins_s pins_raw;
  iorpc_pins_s s1;
  iorpc_pins_s s2;
  iorpc_pins_s s3;
  iorpc_pins_s stab;
  wire  iorpc_pins_s agree = ~(s2 ^ s3);

  assign pins_raw = '{chg_full: i_chg_full, chg_active: i_chg_active,
                      supply: i_charger_supply_in, key_b: i_power_key_b,
                      key_a: i_power_key_a, ext_rst_n: i_ext_reset_n, gpio: i_gpio};

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1   <= PINS_RST;
      s2   <= PINS_RST;
      s3   <= PINS_RST;
      stab <= PINS_RST;
    end else begin
      s1   <= pins_raw;
      s2   <= s1;
      s3   <= s2;
      stab <= (s3 & agree) | (stab & ~agree);
    end
  end

  // Reset filter; a pulse shorter than the interval never resets
  logic [CW-1:0] rst_cnt;
  logic          rst_int;
  wire           filt_hit = (rst_cnt == CW'(RST_FILT_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt <= '0;
      rst_int <= 1'b0;
    end else if (stab.ext_rst_n) begin
      rst_cnt <= '0;
      rst_int <= 1'b0;
    end else if (filt_hit) begin
      rst_int <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 1'b1;
    end
  end

  // Register file
  iorpc_io_ctrl_s  io_ctrl;
  iorpc_pwr_ctrl_s pwr_ctrl;
  iorpc_led_s      led0;
  iorpc_led_s      led1;
  wire hit_io_ctrl  = (i_addr == A_IO_CTRL);
  wire hit_io_stat  = (i_addr == A_IO_STAT);
  wire hit_pwr_ctrl = (i_addr == A_PWR_CTRL);
  wire hit_pwr_stat = (i_addr == A_PWR_STAT);
  wire hit_led0     = (i_addr == A_LED0);
  wire hit_led1     = (i_addr == A_LED1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      io_ctrl  <= IO_CTRL_RST;
      pwr_ctrl <= '0;
      led0     <= '0;
      led1     <= '0;
    end else if (rst_int) begin
      io_ctrl  <= IO_CTRL_RST;
      pwr_ctrl <= '0;
      led0     <= '0;
      led1     <= '0;
    end else if (i_wr) begin
      if (hit_io_ctrl) begin
        io_ctrl <= iorpc_io_ctrl_s'(i_wdata[$bits(iorpc_io_ctrl_s)-1:0]);
      end
      if (hit_pwr_ctrl) begin
        pwr_ctrl <= iorpc_pwr_ctrl_s'(i_wdata[$bits(iorpc_pwr_ctrl_s)-1:0]);
      end
      if (hit_led0) begin
        led0 <= iorpc_led_s'(i_wdata[$bits(iorpc_led_s)-1:0]);
      end
      if (hit_led1) begin
        led1 <= iorpc_led_s'(i_wdata[$bits(iorpc_led_s)-1:0]);
      end
    end
  end

  // Boot reader: one current-address read of the charge setting.
  // Holds while the filtered reset is on so the frame is not torn.
  iorpc_boot_e   boot_st;
  logic [QW-1:0] qcnt;
  logic [1:0]    phase;
  logic [4:0]    bitn;
  logic [7:0]    sh;
  logic          scl;
  logic          sda_lo;
  logic          ee_nack;
  logic [6:0]    chg_ma;
  wire           tick      = !rst_int && (qcnt == QW'(QTR_CYC - 1));
  wire           boot_busy = (boot_st != BT_DONE);
  wire           sda_in    = stab.gpio[LINE_EE_B];
  wire           send_zero = (bitn < ACK_BIT) && !EE_RD_CMD[3'(7 - bitn)];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qcnt <= '0;
    end else if (!boot_busy || tick) begin
      qcnt <= '0;
    end else if (!rst_int) begin
      qcnt <= qcnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_st <= BT_IDLE;
      phase   <= '0;
      bitn    <= '0;
      sh      <= '0;
      scl     <= 1'b1;
      sda_lo  <= 1'b0;
      ee_nack <= 1'b0;
      chg_ma  <= CHG_MIN_MA[6:0];
    end else if (tick) begin
      phase <= phase + 1'b1;
      case (boot_st)
        BT_IDLE: begin
          boot_st <= BT_START;
          phase   <= '0;
        end
        BT_START: begin
          if (phase == 2'd0) begin
            sda_lo <= 1'b1;
          end else begin
            scl     <= 1'b0;
            phase   <= '0;
            bitn    <= '0;
            boot_st <= BT_BIT;
          end
        end
        BT_BIT: begin
          case (phase)
            2'd0: sda_lo <= send_zero;
            2'd1: scl    <= 1'b1;
            2'd2: begin
              if (bitn == ACK_BIT) begin
                ee_nack <= sda_in;
              end else if (bitn > ACK_BIT && bitn <= RD_LAST) begin
                sh <= {sh[6:0], sda_in};
              end
            end
            default: begin
              scl <= 1'b0;
              if (bitn == NACK_BIT) begin
                boot_st <= BT_STOP;
              end else begin
                bitn <= bitn + 1'b1;
              end
            end
          endcase
        end
        BT_STOP: begin
          case (phase)
            2'd0: sda_lo <= 1'b1;
            2'd1: scl    <= 1'b1;
            default: begin
              sda_lo  <= 1'b0;
              chg_ma  <= clamp_ma(sh);
              boot_st <= BT_DONE;
            end
          endcase
        end
        default: boot_st <= BT_DONE;
      endcase
    end
  end

  // Pin drive composition
  logic [NLINE-1:0] sw_oe;
  logic [NLINE-1:0] sw_out;
  logic [NLINE-1:0] next_oe;
  logic [NLINE-1:0] next_out;

  always_comb begin
    sw_oe  = io_ctrl.oe;
    sw_out = io_ctrl.out;
    if (io_ctrl.mic_bias_mode) begin
      sw_oe[LINE_MIC]  = 1'b1;
      sw_out[LINE_MIC] = io_ctrl.mic_bias_on;
    end
    // Reader owns the memory lines until the first boot is done
    if (boot_busy) begin
      sw_oe[LINE_EE_A]  = !scl;
      sw_out[LINE_EE_A] = 1'b0;
      sw_oe[LINE_EE_B]  = sda_lo;
      sw_out[LINE_EE_B] = 1'b0;
    end
    next_oe  = rst_int ? '0 : sw_oe;
    next_out = rst_int ? '0 : sw_out;
  end

  // Power and charger
  wire chg_led   = stab.chg_active && !pwr_ctrl.led_ovr;
  wire next_smps = stab.key_a || stab.key_b || pwr_ctrl.smps_fw || stab.supply;
  wire led0_en   = chg_led || led0.en;
  wire [7:0] led0_lvl = chg_led ? LED_FULL : led0.level;
  logic pwm0_on;
  logic pwm1_on;

  iorpc_pwm #(.W(8)) u_pwm0 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_en    (led0_en),
    .i_level (led0_lvl),
    .o_on    (pwm0_on)
  );

  iorpc_pwm #(.W(8)) u_pwm1 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_en    (led1.en),
    .i_level (led1.level),
    .o_on    (pwm1_on)
  );

  iorpc_pwr_stat_s pwr_stat;
  assign pwr_stat = '{chg_ma: chg_ma, ee_nack: ee_nack, boot_done: !boot_busy,
                      supply: stab.supply, chg_full: stab.chg_full,
                      chg_active: stab.chg_active, pulse_skip: o_smps_pulse_skip,
                      smps_en: o_smps_en};

  wire [DW-1:0] rd_word =
      hit_io_ctrl  ? DW'(io_ctrl)   :
      hit_io_stat  ? DW'(stab.gpio) :
      hit_pwr_ctrl ? DW'(pwr_ctrl)  :
      hit_pwr_stat ? DW'(pwr_stat)  :
      hit_led0     ? DW'(led0)      :
      hit_led1     ? DW'(led1)      : '0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata           <= '0;
      o_gpio_out        <= '0;
      o_gpio_oe         <= '0;
      o_pull_up         <= PULL_RST;
      o_pull_dn         <= ~PULL_RST;
      o_sys_rst_n       <= 1'b0;
      o_smps_en         <= 1'b0;
      o_smps_pulse_skip <= 1'b0;
      o_chg_disable     <= 1'b0;
      o_chg_current     <= CHG_MIN_MA[6:0];
      o_led_out         <= '0;
      o_led_oe          <= '0;
    end else begin
      o_rdata           <= i_rd ? rd_word : '0;
      o_gpio_out        <= next_out;
      o_gpio_oe         <= next_oe;
      o_pull_up         <= io_ctrl.pull_up;
      o_pull_dn         <= ~io_ctrl.pull_up;
      o_sys_rst_n       <= !rst_int;
      o_smps_en         <= next_smps;
      o_smps_pulse_skip <= pwr_ctrl.sniff;
      o_chg_disable     <= pwr_ctrl.chg_off;
      o_chg_current     <= chg_ma;
      o_led_out         <= '0;
      o_led_oe          <= rst_int ? 2'b00 : {pwm1_on, pwm0_on};
    end
  end

  // Checks
  sequence s_rst_enter;
    !rst_int ##1 rst_int;
  endsequence

  sequence s_charging;
    (chg_led && !rst_int) [*4];
  endsequence

  property p_rst_pins;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_rst_enter |=> (o_gpio_oe == '0) && (o_led_oe == 2'b00) && !o_sys_rst_n;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("Pins not released in reset");

  property p_pull_default;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_rst_enter |=> ##1 (o_pull_up == PULL_RST) && (o_pull_dn == ~PULL_RST);
  endproperty
  a_pull_default: assert property (p_pull_default) else $error("Pull default wrong");

  property p_filter_time;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(rst_int) |-> $past(rst_cnt) == CW'(RST_FILT_CYC - 1) && !stab.ext_rst_n;
  endproperty
  a_filter_time: assert property (p_filter_time) else $error("Reset before interval");

  property p_filter_release;
    @(posedge i_clk) disable iff (!i_rst_n)
    rst_int && stab.ext_rst_n |=> !rst_int ##1 o_sys_rst_n;
  endproperty
  a_filter_release: assert property (p_filter_release) else $error("Reset not released");

  property p_smps_on;
    @(posedge i_clk) disable iff (!i_rst_n)
    (stab.key_a || stab.key_b || stab.supply) |=> o_smps_en;
  endproperty
  a_smps_on: assert property (p_smps_on) else $error("Regulator not enabled");

  property p_sniff;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_wr && hit_pwr_ctrl && !rst_int |=> ##1 o_smps_pulse_skip == $past(i_wdata[1], 2);
  endproperty
  a_sniff: assert property (p_sniff) else $error("Pulse skip not following sniff");

  property p_chg_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_wr && hit_pwr_ctrl && !rst_int && i_wdata[2] |=> ##1 o_chg_disable;
  endproperty
  a_chg_off: assert property (p_chg_off) else $error("Charger not disabled");

  property p_led_charge;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_charging |-> o_led_oe[0];
  endproperty
  a_led_charge: assert property (p_led_charge) else $error("Charge LED not full");

  property p_mic_bias;
    @(posedge i_clk) disable iff (!i_rst_n)
    io_ctrl.mic_bias_mode && !rst_int |=> o_gpio_oe[LINE_MIC];
  endproperty
  a_mic_bias: assert property (p_mic_bias) else $error("Mic bias line not driven");

  property p_boot_lines;
    @(posedge i_clk) disable iff (!i_rst_n)
    boot_busy && !rst_int && !scl |=> o_gpio_oe[LINE_EE_A] && !o_gpio_out[LINE_EE_A];
  endproperty
  a_boot_lines: assert property (p_boot_lines) else $error("Boot clock not driven");

  property p_read_data;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == '0;
  endproperty
  a_read_data: assert property (p_read_data) else $error("Read data outside slot");

endmodule
`default_nettype wire

//--- dv/iorpc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module iorpc_mem_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter logic [7:0] RD_BYTE  = 8'h4B
) (
  input  wire logic i_scl,     // Serial clock line level
  input  wire logic i_sda,     // Serial data line level
  output logic      o_sda_low = 1'b0  // Pulls data line low
);
  int         bits = -1;
  logic [7:0] cmd  = 8'h00;

  // Data edges while clock high frame a transfer
  always @(i_sda) begin
    if (i_scl === 1'b1 && i_sda === 1'b0)
      bits = 0;
    else if (i_scl === 1'b1 && i_sda === 1'b1)
      bits = -1;
  end

  always @(posedge i_scl) begin
    if (bits >= 0) begin
      if (bits < 8)
        cmd = {cmd[6:0], i_sda};
      bits++;
    end
  end

  // Released data falls back to the pull-up, never the last value
  always @(negedge i_scl) begin
    if (bits == 8)
      o_sda_low = (cmd == {DEV_ADDR, 1'b1});
    else if (bits >= 9 && bits <= 16)
      o_sda_low = ~RD_BYTE[16-bits];
    else
      o_sda_low = 1'b0;
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import iorpc_pkg::*;
();
  localparam int FILT = 50;
  logic          i_clk, i_rst_n, i_wr, i_rd;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata, o_rdata, rd_data;
  logic [3:0]    gpio_out, gpio_oe, pull_up, pull_dn, ext_oe, ext_val, lvl;
  logic          ext_rst_n, key_a, key_b, supply, chg_act, chg_full;
  logic          sys_rst_n, smps_en, pskip, chg_dis, mem_low;
  logic [6:0]    chg_cur;
  logic [1:0]    led_out, led_oe;
  int            errors = 0;
  int            check_count = 0;
  int            cyc = 0;
  int            n;

  iorpc_top #(.RST_FILT_CYC(FILT), .QTR_CYC(4)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_gpio(lvl),
    .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe), .o_pull_up(pull_up),
    .o_pull_dn(pull_dn), .i_ext_reset_n(ext_rst_n), .i_power_key_a(key_a),
    .i_power_key_b(key_b), .i_charger_supply_in(supply), .i_chg_active(chg_act),
    .i_chg_full(chg_full), .o_sys_rst_n(sys_rst_n), .o_smps_en(smps_en),
    .o_smps_pulse_skip(pskip), .o_chg_disable(chg_dis), .o_chg_current(chg_cur),
    .o_led_out(led_out), .o_led_oe(led_oe));

  iorpc_mem_model mem (.i_scl(lvl[0]), .i_sda(lvl[1]), .o_sda_low(mem_low));

  // Undriven lines settle to whichever pull is enabled
  always_comb begin
    for (int i = 0; i < 4; i++)
      lvl[i] = gpio_oe[i] ? gpio_out[i] : ext_oe[i] ? ext_val[i] : pull_up[i];
    lvl[1] = lvl[1] & ~mem_low;
  end

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    rd_data = o_rdata;
  endtask

  task automatic count_on(input int idx);
    n = 0;
    repeat (256) begin
      @(negedge i_clk);
      n += int'(led_oe[idx]);
    end
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    {i_rst_n, i_wr, i_rd} = 3'b000;
    i_addr = '0;
    i_wdata = '0;
    {ext_oe, ext_val} = 8'h00;
    {ext_rst_n, key_a, key_b, supply, chg_act, chg_full} = 6'b100000;
    repeat (10) @(posedge i_clk);
    #1;
    chk("pull_up", 4'h7, pull_up);
    chk("pull_dn", 4'h8, pull_dn);
    chk("oe", 6'h00, {gpio_oe, led_oe});
    chk("sys_rst_n", 1'b0, sys_rst_n);
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(A_IO_CTRL);
    chk("io_ctrl", 32'h0000_0700, rd_data);
    rd(8'h20);
    chk("unmapped", 32'h0000_0000, rd_data);
    n = 0;
    do begin
      rd(A_PWR_STAT);
      n++;
    end while (rd_data[5] !== 1'b1 && n < 400);
    chk("chg_cur", 7'd75, chg_cur);
    chk("pwr_stat", {7'd75, 2'b01}, rd_data[13:5]);
    // Line 2 pulled down but driven high from outside
    wr(A_IO_CTRL, 32'h0000_0A88);
    @(posedge i_clk);
    ext_oe <= 4'h4;
    ext_val <= 4'h4;
    cycles(6);
    chk("pull_up", 4'hA, pull_up);
    chk("pull_dn", 4'h5, pull_dn);
    chk("oe_out", 8'h88, {gpio_oe, gpio_out});
    rd(A_IO_STAT);
    chk("io_stat", 4'hE, rd_data[3:0]);
    @(posedge i_clk);
    ext_oe <= 4'h0;
    wr(A_IO_CTRL, 32'h0000_3A88);
    cycles(3);
    chk("mic_bias", 8'hCC, {gpio_oe, gpio_out});
    for (int k = 0; k < 5; k++) begin
      @(posedge i_clk);
      key_a <= (k == 0);
      key_b <= (k == 1);
      supply <= (k == 2);
      wr(A_PWR_CTRL, 32'(k == 3));
      cycles(8);
      chk("smps_en", k < 4, smps_en);
    end
    wr(A_PWR_CTRL, 32'h0000_0006);
    cycles(3);
    chk("pulse_skip", 1'b1, pskip);
    chk("chg_disable", 1'b1, chg_dis);
    @(posedge i_clk);
    chg_act <= 1'b1;
    chg_full <= 1'b1;
    cycles(6);
    rd(A_PWR_STAT);
    chk("chg_status", 2'b11, rd_data[3:2]);
    count_on(0);
    chk("led0_full", 256, n);
    wr(A_PWR_CTRL, 32'h0000_0008);
    cycles(4);
    count_on(0);
    chk("led0_ovr", 0, n);
    wr(A_LED1, 32'h0000_0140);
    cycles(4);
    count_on(1);
    chk("led1_duty", 64, n);
    chk("led_out", 2'b00, led_out);
    // Pulse shorter than the filter must leave the chip running
    @(posedge i_clk);
    ext_rst_n <= 1'b0;
    repeat (FILT - 20) @(posedge i_clk);
    ext_rst_n <= 1'b1;
    cycles(10);
    chk("short_pulse", 1'b1, sys_rst_n);
    @(posedge i_clk);
    ext_rst_n <= 1'b0;
    n = 0;
    while (sys_rst_n === 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    chk("filt_delay", 1'b1, n >= FILT && n <= FILT + 6);
    cycles(2);
    chk("rst_pins", 6'h00, {gpio_oe, led_oe});
    @(posedge i_clk);
    ext_rst_n <= 1'b1;
    cycles(8);
    chk("rst_release", 1'b1, sys_rst_n);
    rd(A_IO_CTRL);
    chk("io_ctrl_rst", 32'h0000_0700, rd_data);
    end_of_test();
  end
endmodule
`default_nettype wire
